// ===== hdl/ecc_edge.sv
// Purpose: Rise and fall detection on a group of synchronous inputs.
// Assumes: Inputs already synchronous to clk.
// Notes: Previous values reset to the idle level given.
`timescale 1ns/1ps
module ecc_edge #(
  parameter int W = 8,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] sig,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] prev_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= IDLE;
    end else begin
      prev_q <= sig;
    end
  end

  assign rise = sig & ~prev_q;
  assign fall = ~sig & prev_q;
endmodule : ecc_edge

// ===== hdl/ecc_pulse.sv
// Purpose: Self-terminating pulse of a fixed cycle count.
// Assumes: Trigger is a one-cycle pulse.
// Notes: A trigger during the pulse restarts the count.
`timescale 1ns/1ps
module ecc_pulse #(
  parameter int N = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic trig,
  output logic active
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= 8'h00;
    end else if (trig) begin
      cnt_q <= 8'(N);
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  assign active = trig || (cnt_q > 8'h01);
endmodule : ecc_pulse

// ===== hdl/ecc_top.sv
// Purpose: Emulation cycle control: status pass, break, halt, latch, wait/ack.
// Assumes: All pod and bus inputs synchronous to clk; AXI4-Lite registers.
// Notes: Software reset of the board maps onto srst.
//
// Summary of operation
// - Pod status 3-7 passed to bus status
// - Status 2,1 are delayed byte enables
// - Status 0 and bus write follow write
// - Falling break request edge sets break flag
// - Break output is flag XOR polarity bit
// - Polarity high gives active-low break output
// - Interrupt enable lets break activity raise irq
// - Halt control bit asserts halt to pod
// - Refresh request also asserts halt to pod
// - Latch strobe rise loads last address
// - Cycle arms, analysis rise makes latch strobe
// - Memory break status low blocks analysis latch strobes, not pulse strobes
// - Mapper write or address load starts pulse
// - Pod read strobe also starts latch pulse
// - Refresh acknowledge follows pod grant
// - Wait mode sets wait flag in emulation space
// - Memory ready one-shot clears wait flag
// - Handshake output active level is polarity select bit
// - Ack mode: held off, ready sets ack
// - Cycle end clears acknowledge flag
// - Fast wait asserted until ready presets flag
`timescale 1ns/1ps
module ecc_top
  import ecc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pod and emulation bus
  input wire logic [7:3] pod_status_in,
  input wire logic upper_byte_enable,
  input wire logic byte_cycle_strobe,
  input wire logic pod_write_cycle,
  output logic [7:0] bus_status_out,
  output logic bus_write_out,
  input wire logic bus_break_request,
  output logic break_to_pod,
  output logic mainframe_irq_n,
  input wire logic refresh_request_in,
  output logic halt_to_pod,
  input wire logic pod_refresh_grant,
  output logic refresh_ack_out,
  input wire logic [23:0] emu_addr,
  input wire logic analysis_strobe,
  input wire logic memory_break_status,
  input wire logic mapper_write_pulse,
  input wire logic pod_addr_load,
  input wire logic pod_read_strobe,
  output logic addr_latch_strobe,
  input wire logic cycle_start_strobe,
  input wire logic mem_cycle_active_n,
  input wire logic mapper_emu_space,
  input wire logic mem_ready,
  output logic wait_to_pod,
  output logic fast_wait_n
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] ctrl_q;
  logic break_q;
  logic wait_q;
  logic ack_q;
  logic [23:0] last_addr_q;
  logic aw_rdy_q;
  logic ar_rdy_q;
  logic bvalid_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q;
  logic [1:0] rresp_q;
  logic [7:0] bus_status_q;
  logic bus_write_q;
  logic break_out_q;
  logic irq_n_q;
  logic halt_q;
  logic refresh_ack_q;
  logic strobe_q;
  logic strobe_d;
  logic hs_q;
  logic fast_n_q;
  logic [EG_WIDTH-1:0] edge_in;
  logic [EG_WIDTH-1:0] rise;
  logic [EG_WIDTH-1:0] fall;
  logic [STATUS_DELAY_STAGES:0] bup_dly;
  logic [STATUS_DELAY_STAGES:0] byte_dly;
  logic wr_fire;
  logic rd_fire;
  logic pulse_trig;
  logic pulse_on;
  logic norm_strobe;
  logic ready_pulse;
  logic wait_mode;
  logic ack_mode;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction : hit

  // ****************************************
  // Edge detection
  // ****************************************
  assign edge_in[EG_BUS_BREAK] = bus_break_request;
  assign edge_in[EG_SOFT_BREAK] = ctrl_q[CB_SOFT_BREAK];
  assign edge_in[EG_ANAL] = analysis_strobe;
  assign edge_in[EG_CYC] = cycle_start_strobe;
  assign edge_in[EG_READY] = mem_ready;
  assign edge_in[EG_MAPWR] = mapper_write_pulse;
  assign edge_in[EG_ADDRLD] = pod_addr_load;
  assign edge_in[EG_PODRD] = pod_read_strobe;

  ecc_edge #(
    .W(EG_WIDTH),
    .IDLE(8'hA3)
  ) u_edge (
    .clk(clk),
    .srst(srst),
    .sig(edge_in),
    .rise(rise),
    .fall(fall)
  );

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  assign wr_fire = aw_rdy_q && s_axi_awvalid && s_axi_wvalid;
  assign rd_fire = ar_rdy_q && s_axi_arvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_rdy_q <= !aw_rdy_q && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= (hit(s_axi_awaddr, CTRL_OFF) || hit(s_axi_awaddr, STAT_OFF) ||
                    hit(s_axi_awaddr, ADDR_OFF)) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ar_rdy_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else begin
      ar_rdy_q <= !ar_rdy_q && s_axi_arvalid && !rvalid_q;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q <= RESP_OKAY;
        if (hit(s_axi_araddr, CTRL_OFF)) begin
          rdata_q <= {24'h00_0000, ctrl_q};
        end else if (hit(s_axi_araddr, STAT_OFF)) begin
          rdata_q <= {29'h0000_0000, ack_q, wait_q, break_q};
        end else if (hit(s_axi_araddr, ADDR_OFF)) begin
          rdata_q <= {8'h00, last_addr_q};
        end else begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = aw_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_fire && hit(s_axi_awaddr, CTRL_OFF) && s_axi_wstrb[0]) begin
      ctrl_q <= s_axi_wdata[7:0];
    end
  end

  assign wait_mode = ctrl_q[CB_HS_EN] && ctrl_q[CB_WAIT_SEL];
  assign ack_mode = ctrl_q[CB_HS_EN] && !ctrl_q[CB_WAIT_SEL];

  // ****************************************
  // Analysis status lines
  // ****************************************
  assign bup_dly[0] = upper_byte_enable;
  assign byte_dly[0] = byte_cycle_strobe;

  generate
    for (genvar i = 1; i <= STATUS_DELAY_STAGES; i++) begin : g_dly
      logic bup_q;
      logic byte_q;
      always_ff @(posedge clk) begin
        if (srst) begin
          bup_q <= 1'b1;
          byte_q <= 1'b1;
        end else begin
          bup_q <= bup_dly[i-1];
          byte_q <= byte_dly[i-1];
        end
      end
      assign bup_dly[i] = bup_q;
      assign byte_dly[i] = byte_q;
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_status_q <= 8'hFF;
      bus_write_q <= 1'b1;
    end else begin
      bus_status_q[7:3] <= pod_status_in;
      bus_status_q[2] <= bup_dly[STATUS_DELAY_STAGES];
      bus_status_q[1] <= byte_dly[STATUS_DELAY_STAGES];
      bus_status_q[0] <= pod_write_cycle;
      bus_write_q <= pod_write_cycle;
    end
  end

  assign bus_status_out = bus_status_q;
  assign bus_write_out = bus_write_q;

  // ****************************************
  // Break and interrupt
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      break_q <= 1'b0;
    end else if (fall[EG_BUS_BREAK] || fall[EG_SOFT_BREAK]) begin
      break_q <= 1'b1;
    end else if (wr_fire && hit(s_axi_awaddr, STAT_OFF) && s_axi_wstrb[0] &&
                 s_axi_wdata[SB_BREAK]) begin
      break_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      break_out_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      break_out_q <= break_q ^ ctrl_q[CB_BREAK_POL];
      irq_n_q <= !(ctrl_q[CB_IRQ_EN] &&
                   (!bus_break_request || !ctrl_q[CB_SOFT_BREAK]));
    end
  end

  assign break_to_pod = break_out_q;
  assign mainframe_irq_n = irq_n_q;

  // ****************************************
  // Halt and refresh
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      halt_q <= 1'b0;
      refresh_ack_q <= 1'b0;
    end else begin
      halt_q <= ctrl_q[CB_HALT] || refresh_request_in;
      refresh_ack_q <= pod_refresh_grant;
    end
  end

  assign halt_to_pod = halt_q;
  assign refresh_ack_out = refresh_ack_q;

  // ****************************************
  // Last address latch
  // ****************************************
  assign pulse_trig = fall[EG_MAPWR] || rise[EG_ADDRLD] || fall[EG_PODRD];

  ecc_pulse #(
    .N(LATCH_PULSE_CYC)
  ) u_pulse (
    .clk(clk),
    .srst(srst),
    .trig(pulse_trig),
    .active(pulse_on)
  );

  assign norm_strobe = rise[EG_ANAL] && cycle_start_strobe && memory_break_status;
  assign strobe_d = pulse_on || norm_strobe;

  always_ff @(posedge clk) begin
    if (srst) begin
      strobe_q <= 1'b0;
      last_addr_q <= 24'h00_0000;
    end else begin
      strobe_q <= strobe_d;
      if (strobe_d && !strobe_q) begin
        last_addr_q <= emu_addr;
      end
    end
  end

  assign addr_latch_strobe = strobe_q;

  // ****************************************
  // Wait, acknowledge, fast wait
  // ****************************************
  assign ready_pulse = rise[EG_READY];

  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q <= 1'b0;
    end else if (rise[EG_CYC] && mapper_emu_space && wait_mode) begin
      wait_q <= 1'b1;
    end else if (ready_pulse) begin
      wait_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else if (ready_pulse) begin
      ack_q <= 1'b1;
    end else if (rise[EG_CYC]) begin
      ack_q <= !mapper_emu_space;
    end else if (mem_cycle_active_n) begin
      ack_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hs_q <= 1'b0;
      fast_n_q <= 1'b1;
    end else begin
      hs_q <= ((wait_mode && wait_q) || (ack_mode && ack_q)) ~^ ctrl_q[CB_HS_POL];
      fast_n_q <= ctrl_q[CB_FAST_EN] || ack_q;
    end
  end

  assign wait_to_pod = hs_q;
  assign fast_wait_n = fast_n_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_status_pass: assert property (##1 bus_status_out[7:3] == $past(pod_status_in))
    else $error("status 3-7 not passed");
  a_byte_delay: assert property (##3 bus_status_out[2:1] ==
      {$past(upper_byte_enable, 3), $past(byte_cycle_strobe, 3)})
    else $error("byte status delay wrong");
  a_write_fwd: assert property (##1 {bus_status_out[0], bus_write_out} ==
      {2{$past(pod_write_cycle)}})
    else $error("write indication mismatch");
  a_break_set: assert property ($fell(bus_break_request) |=> break_q)
    else $error("break flag not set");
  a_break_pol: assert property (##1 break_to_pod ==
      ($past(break_q) ^ $past(ctrl_q[CB_BREAK_POL])))
    else $error("break polarity wrong");
  a_irq_req: assert property (ctrl_q[CB_IRQ_EN] && !bus_break_request
      && !$past(srst) |=> !mainframe_irq_n)
    else $error("irq not raised");
  a_halt_req: assert property (ctrl_q[CB_HALT] || refresh_request_in |=> halt_to_pod)
    else $error("halt not asserted");
  a_addr_load: assert property ($rose(addr_latch_strobe) |-> last_addr_q == $past(emu_addr))
    else $error("last address not loaded");
  a_latch_block: assert property ($rose(analysis_strobe) && !memory_break_status &&
      !pulse_on |=> !addr_latch_strobe)
    else $error("latch not blocked");
  a_latch_pulse: assert property ($fell(mapper_write_pulse) |=> addr_latch_strobe [*3]
      ##1 (!addr_latch_strobe || pulse_on || $past(norm_strobe)))
    else $error("latch pulse length wrong");
  a_wait_clear: assert property ($rose(mem_ready) && !(rise[EG_CYC] && wait_mode
      && mapper_emu_space) |=> !wait_q)
    else $error("wait not cleared");
  a_ack_user: assert property ($rose(cycle_start_strobe) && !mapper_emu_space |=> ack_q)
    else $error("user space not released");
endmodule : ecc_top

// ===== inc/ecc_pkg.sv
// Purpose: Shared constants for the emulation cycle control block.
// Assumes: 50 MHz system clock, AXI4-Lite register access.
// Notes: Offsets are byte addresses of 32-bit words.
package ecc_pkg;
  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int LATCH_PULSE_NS = 60;
  localparam int LATCH_PULSE_CYC = (LATCH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_DELAY_STAGES = 2;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] ADDR_OFF = 8'h08;

  // ****************************************
  // Control bit positions
  // ****************************************
  localparam int CB_SOFT_BREAK = 0;
  localparam int CB_BREAK_POL = 1;
  localparam int CB_IRQ_EN = 2;
  localparam int CB_HALT = 3;
  localparam int CB_HS_EN = 4;
  localparam int CB_WAIT_SEL = 5;
  localparam int CB_HS_POL = 6;
  localparam int CB_FAST_EN = 7;
  localparam logic [7:0] CTRL_RESET = 8'h81;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int SB_BREAK = 0;
  localparam int SB_WAIT = 1;
  localparam int SB_ACK = 2;

  // ****************************************
  // Edge detector lanes
  // ****************************************
  localparam int EG_BUS_BREAK = 0;
  localparam int EG_SOFT_BREAK = 1;
  localparam int EG_ANAL = 2;
  localparam int EG_CYC = 3;
  localparam int EG_READY = 4;
  localparam int EG_MAPWR = 5;
  localparam int EG_ADDRLD = 6;
  localparam int EG_PODRD = 7;
  localparam int EG_WIDTH = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ecc_pkg

// ===== test/ecc_mem_model.sv
// Purpose: Emulation memory model that answers memory cycles with a ready pulse.
// Assumes: Cycle start is the rise of the cycle strobe; delay set by the bench.
// Notes: Ready is held until the cycle strobe falls, low otherwise.
`timescale 1ns/1ps
module ecc_mem_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic cycle_start_strobe,
  input wire logic mapper_emu_space,
  input wire logic [3:0] ready_delay,
  output logic mem_ready
);
  logic prev_q;
  logic busy_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clk) begin
    prev_q <= cycle_start_strobe;
    if (srst || !cycle_start_strobe) begin
      busy_q <= 1'h0;
      mem_ready <= 1'h0;
    end else if (!prev_q && mapper_emu_space) begin
      busy_q <= 1'h1;
      cnt_q <= ready_delay;
    end else if (busy_q && cnt_q <= 4'h1) begin
      mem_ready <= 1'h1;
      busy_q <= 1'h0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : ecc_mem_model

// ===== test/emulation_cycle_control_tb.sv
// Purpose: Self-checking bench for the emulation cycle control block.
// Assumes: AXI4-Lite master tasks; memory model on the far side.
// Notes: Outputs are read at the clock edge, before that edge's updates.
`timescale 1ns/1ps
module emulation_cycle_control_tb;
  import ecc_pkg::*;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:3] pod_status_in = 5'h1F;
  logic upper_byte_enable = 1'h1, byte_cycle_strobe = 1'h1, pod_write_cycle = 1'h1;
  logic bus_break_request = 1'h1, refresh_request_in = 1'h0, pod_refresh_grant = 1'h0;
  logic analysis_strobe = 1'h0, memory_break_status = 1'h1, mapper_write_pulse = 1'h1;
  logic pod_addr_load = 1'h0, pod_read_strobe = 1'h1, cycle_start_strobe = 1'h0;
  logic mem_cycle_active_n = 1'h1, mapper_emu_space = 1'h0, mem_ready;
  logic [23:0] emu_addr = 24'h0;
  logic [3:0] mem_delay = 4'h5;
  logic [7:0] bus_status_out;
  logic bus_write_out, break_to_pod, mainframe_irq_n, halt_to_pod, refresh_ack_out;
  logic addr_latch_strobe, wait_to_pod, fast_wait_n;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rv;

  ecc_top DUT (.clk(clk), .srst(srst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pod_status_in(pod_status_in),
    .upper_byte_enable(upper_byte_enable), .byte_cycle_strobe(byte_cycle_strobe),
    .pod_write_cycle(pod_write_cycle), .bus_status_out(bus_status_out),
    .bus_write_out(bus_write_out), .bus_break_request(bus_break_request),
    .break_to_pod(break_to_pod), .mainframe_irq_n(mainframe_irq_n),
    .refresh_request_in(refresh_request_in), .halt_to_pod(halt_to_pod),
    .pod_refresh_grant(pod_refresh_grant), .refresh_ack_out(refresh_ack_out),
    .emu_addr(emu_addr), .analysis_strobe(analysis_strobe),
    .memory_break_status(memory_break_status), .mapper_write_pulse(mapper_write_pulse),
    .pod_addr_load(pod_addr_load), .pod_read_strobe(pod_read_strobe),
    .addr_latch_strobe(addr_latch_strobe), .cycle_start_strobe(cycle_start_strobe),
    .mem_cycle_active_n(mem_cycle_active_n), .mapper_emu_space(mapper_emu_space),
    .mem_ready(mem_ready), .wait_to_pod(wait_to_pod), .fast_wait_n(fast_wait_n));
  ecc_mem_model mem (.clk(clk), .srst(srst), .cycle_start_strobe(cycle_start_strobe),
    .mapper_emu_space(mapper_emu_space), .ready_delay(mem_delay), .mem_ready(mem_ready));

  always #10 clk = ~clk;

  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_of_test;
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do @(posedge clk); while (s_axi_awready !== 1'h1);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask : rd

  task automatic cnt_strobe(input int exp);
    int c;
    c = 0;
    repeat (8) begin
      @(posedge clk);
      if (addr_latch_strobe === 1'h1) c++;
    end
    chk("latch strobe cycles", exp, c);
  endtask : cnt_strobe

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd(CTRL_OFF, RESP_OKAY, rv);
    chk("ctrl reset", {24'h0, CTRL_RESET}, rv);
    rd(8'h0C, RESP_SLVERR, rv);
    chk("unmapped read", 32'h0, rv);
    wr(8'h0C, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask : t_regs

  task automatic t_status;
    pod_status_in <= 5'h0A;
    upper_byte_enable <= 1'h0;
    pod_write_cycle <= 1'h0;
    tick(2);
    chk("bus status early", 8'h56, bus_status_out);
    chk("bus write", 1'h0, bus_write_out);
    tick(3);
    chk("bus status late", 8'h52, bus_status_out);
    pod_status_in <= 5'h1F;
    upper_byte_enable <= 1'h1;
    pod_write_cycle <= 1'h1;
    tick(5);
    chk("bus status idle", 8'hFF, bus_status_out);
  endtask : t_status

  task automatic t_break;
    wr(CTRL_OFF, 32'h85, RESP_OKAY);
    bus_break_request <= 1'h0;
    tick(2);
    chk("irq on activity", 1'h0, mainframe_irq_n);
    tick(3);
    chk("break high level", 1'h1, break_to_pod);
    bus_break_request <= 1'h1;
    tick(3);
    chk("irq idle", 1'h1, mainframe_irq_n);
    wr(CTRL_OFF, 32'h87, RESP_OKAY);
    tick(3);
    chk("break low level", 1'h0, break_to_pod);
    wr(STAT_OFF, 32'h1, RESP_OKAY);
    tick(3);
    chk("break cleared", 1'h1, break_to_pod);
    wr(CTRL_OFF, 32'h82, RESP_OKAY);
    tick(4);
    chk("soft break", 1'h0, break_to_pod);
    chk("irq masked", 1'h1, mainframe_irq_n);
    rd(STAT_OFF, RESP_OKAY, rv);
    chk("break flag", 32'h1, rv & 32'h1);
    wr(STAT_OFF, 32'h1, RESP_OKAY);
    wr(CTRL_OFF, 32'h81, RESP_OKAY);
    tick(3);
    chk("break idle", 1'h0, break_to_pod);
  endtask : t_break

  task automatic t_halt;
    wr(CTRL_OFF, 32'h89, RESP_OKAY);
    tick(2);
    chk("soft halt", 1'h1, halt_to_pod);
    wr(CTRL_OFF, 32'h81, RESP_OKAY);
    refresh_request_in <= 1'h1;
    pod_refresh_grant <= 1'h1;
    tick(2);
    chk("refresh halt", 1'h1, halt_to_pod);
    chk("refresh ack", 1'h1, refresh_ack_out);
    refresh_request_in <= 1'h0;
    pod_refresh_grant <= 1'h0;
    tick(2);
    chk("halt idle", 1'h0, halt_to_pod);
    chk("ack idle", 1'h0, refresh_ack_out);
  endtask : t_halt

  task automatic t_latch;
    emu_addr <= 24'h123456;
    cycle_start_strobe <= 1'h1;
    tick(2);
    analysis_strobe <= 1'h1;
    cnt_strobe(1);
    rd(ADDR_OFF, RESP_OKAY, rv);
    chk("last addr", 32'h123456, rv);
    analysis_strobe <= 1'h0;
    memory_break_status <= 1'h0;
    emu_addr <= 24'h00ABCD;
    tick(2);
    analysis_strobe <= 1'h1;
    cnt_strobe(0);
    rd(ADDR_OFF, RESP_OKAY, rv);
    chk("frozen addr", 32'h123456, rv);
    analysis_strobe <= 1'h0;
    cycle_start_strobe <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      emu_addr <= 24'h0F0F00 + 24'(i);
      mapper_write_pulse <= (i != 0);
      pod_addr_load <= (i == 1);
      pod_read_strobe <= (i != 2);
      cnt_strobe(LATCH_PULSE_CYC);
      mapper_write_pulse <= 1'h1;
      pod_addr_load <= 1'h0;
      pod_read_strobe <= 1'h1;
      rd(ADDR_OFF, RESP_OKAY, rv);
      chk("pulse addr", 32'h0F0F00 + i, rv);
    end
    memory_break_status <= 1'h1;
  endtask : t_latch

  task automatic mcycle(input logic emu, input int t1, input logic e1, input int t2,
      input logic e2, input string nm);
    mapper_emu_space <= emu;
    mem_cycle_active_n <= 1'h0;
    cycle_start_strobe <= 1'h1;
    tick(t1);
    chk({nm, " start"}, e1, wait_to_pod & fast_wait_n);
    tick(t2);
    chk({nm, " ready"}, e2, wait_to_pod & fast_wait_n);
    cycle_start_strobe <= 1'h0;
    mem_cycle_active_n <= 1'h1;
    tick(3);
  endtask : mcycle

  task automatic t_handshake;
    wr(CTRL_OFF, 32'hB1, RESP_OKAY);
    mcycle(1'h1, 4, 1'h0, 8, 1'h1, "wait low");
    wr(CTRL_OFF, 32'hF1, RESP_OKAY);
    mcycle(1'h1, 4, 1'h1, 8, 1'h0, "wait high");
    mcycle(1'h0, 4, 1'h0, 8, 1'h0, "wait user");
    wr(CTRL_OFF, 32'h91, RESP_OKAY);
    mcycle(1'h1, 4, 1'h1, 8, 1'h0, "ack emu");
    chk("ack end", 1'h1, wait_to_pod);
    mcycle(1'h0, 3, 1'h0, 1, 1'h0, "ack user");
    wr(CTRL_OFF, 32'h01, RESP_OKAY);
    mcycle(1'h1, 4, 1'h0, 8, 1'h1, "fast emu");
    chk("fast end", 1'h0, fast_wait_n);
    mem_delay <= 4'h1;
    mcycle(1'h0, 3, 1'h1, 1, 1'h1, "fast user");
    mcycle(1'h1, 8, 1'h1, 1, 1'h1, "fast prompt");
    wr(CTRL_OFF, 32'h81, RESP_OKAY);
  endtask : t_handshake

  initial begin
    tick(8);
    srst <= 1'h0;
    tick(1);
    t_regs();
    t_status();
    t_break();
    t_halt();
    t_latch();
    t_handshake();
    end_of_test();
  end
endmodule : emulation_cycle_control_tb
